// [rtl/reset_strap_config_decoder.sv]
// reset strap capture, decode, shared pin steering and ahb-lite status registers
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module reset_strap_config_decoder
    import strap_cfg_pkg::*;
(
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 pci_select_strap,
    input  wire logic                 byte_order_strap,
    input  wire logic [1:0]           boot_select_strap,
    input  wire logic [1:0]           memory_clock_select_strap,
    input  wire logic                 eeprom_autoinit_strap,
    input  wire logic                 host_width_strap,
    output logic                      host_port_enable,
    output logic                      pci_enable,
    output logic                      little_endian,
    output boot_mode_e                boot_mode,
    output mem_clk_e                  memory_clock_source,
    output logic                      pci_eeprom_autoinit,
    output logic                      host_port_wide,
    output logic                      host_data_upper_oe_n,
    output logic                      pci_only_pins_oe_n,
    output logic [GPIO_W-1:0]         shared_gpio_func,
    output logic [GPIO_W-1:0]         shared_gpio_oe_n
);
    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // straps are sampled by the clocked process while reset is low and on the first two edges after release;
    // the async reset only loads constants, the documented defaults
    logic       cap_pci;
    logic       cap_byte_order_strap;
    logic [1:0] cap_boot;
    logic [1:0] cap_mclk;
    logic       cap_eeprom_autoinit_strap;
    logic       cap_hwid;
    logic       captured;
    logic       rst_s1;
    logic       rst_s2;

    // synchronised release so capture keeps running until reset is gone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    wire capture_window = !rst_s2;

    always_ff @(posedge hclk) begin
        if (capture_window) begin
            cap_pci  <= pci_select_strap;
            cap_byte_order_strap <= byte_order_strap;
            cap_boot <= boot_select_strap;
            cap_mclk <= memory_clock_select_strap;
            cap_eeprom_autoinit_strap <= eeprom_autoinit_strap;
            cap_hwid <= host_width_strap;
        end
        // outside the window the captured values simply hold
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            captured <= 1'b0;
        end else if (rst_s2) begin
            captured <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // until capture completes the defaults stand: host port, no pci
    wire sel_pci   = captured & cap_pci;
    wire sel_host  = !sel_pci;
    wire dec_byte_order_strap  = captured ? cap_byte_order_strap : 1'b1;
    wire [1:0] dec_boot = captured ? cap_boot : BOOT_ROM8;
    wire [1:0] dec_mclk = captured ? cap_mclk : MCLK_INPUT;
    wire dec_eeprom_autoinit_strap  = captured & cap_eeprom_autoinit_strap & sel_pci;
    wire dec_wide  = captured & cap_hwid;
    wire boot_rsv  = captured & (cap_boot == BOOT_RSV);
    wire mclk_rsv  = captured & (cap_mclk == MCLK_RSV);
    wire ee_confl  = captured & cap_eeprom_autoinit_strap & !cap_pci;

    // ------------------------------------------------------------
    // software gpio control
    // ------------------------------------------------------------
    logic [GPIO_W-1:0] gpio_enable;
    logic [GPIO_W-1:0] gpio_direction;

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    logic       ph_valid;
    logic       ph_write;
    logic [7:0] ph_addr;

    wire        take     = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire        wr_en    = ph_valid & ph_write & (ph_addr == REG_GPIO_ENABLE);
    wire        wr_dir   = ph_valid & ph_write & (ph_addr == REG_GPIO_DIR);
    wire        rd_en    = take & !hwrite;

    wire [31:0] status_word = {20'h0_0000,
                               captured, ee_confl, mclk_rsv, boot_rsv,
                               dec_wide, dec_eeprom_autoinit_strap, dec_mclk, dec_boot,
                               dec_byte_order_strap, sel_pci};

    logic [31:0] rd_mux;
    always_comb begin
        unique case (haddr[7:0])
            REG_STRAP_STATUS: rd_mux = status_word;
            REG_GPIO_ENABLE:  rd_mux = {25'h000_0000, gpio_enable};
            REG_GPIO_DIR:     rd_mux = {25'h000_0000, gpio_direction};
            REG_PIN_SELECT:   rd_mux = {25'h000_0000, shared_gpio_func};
            REG_ID:           rd_mux = BLOCK_ID;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
            hrdata   <= 32'h0000_0000;
        end else begin
            ph_valid <= take;
            ph_write <= hwrite;
            ph_addr  <= haddr[7:0];
            if (rd_en) begin
                hrdata <= rd_mux;
            end
        end
    end

    // zero-wait slave: always ready, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // software may rewrite these at any moment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gpio_enable    <= GPIO_EN_RST;
            gpio_direction <= GPIO_DIR_RST;
        end else begin
            if (wr_en) begin
                gpio_enable <= hwdata[GPIO_W-1:0];
            end
            if (wr_dir) begin
                gpio_direction <= hwdata[GPIO_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // pin steering
    // ------------------------------------------------------------
    // per pin: gpio only when pci is off and software enabled it
    logic [GPIO_W-1:0] next_gpio_func;
    logic [GPIO_W-1:0] next_gpio_oe_n;
    genvar g;
    generate
        for (g = 0; g < GPIO_W; g++) begin : gpio_pin
            assign next_gpio_func[g] = sel_host & gpio_enable[g];
            // direction 1 drives the pin; pci-owned pins are driven by pci logic
            assign next_gpio_oe_n[g] = !(next_gpio_func[g] & gpio_direction[g]);
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_port_enable     <= 1'b1;
            pci_enable           <= 1'b0;
            little_endian        <= 1'b1;
            boot_mode            <= BOOT_ROM8;
            memory_clock_source  <= MCLK_INPUT;
            pci_eeprom_autoinit  <= 1'b0;
            host_port_wide       <= 1'b0;
            host_data_upper_oe_n <= 1'b1;
            pci_only_pins_oe_n   <= 1'b1;
            shared_gpio_func     <= 7'h00;
            shared_gpio_oe_n     <= 7'h7F;
        end else begin
            host_port_enable     <= sel_host;
            pci_enable           <= sel_pci;
            little_endian        <= dec_byte_order_strap;
            boot_mode            <= boot_mode_e'(dec_boot);
            memory_clock_source  <= mem_clk_e'(dec_mclk);
            pci_eeprom_autoinit  <= dec_eeprom_autoinit_strap;
            host_port_wide       <= dec_wide & sel_host;
            // upper host data lanes stay released unless wide host mode
            host_data_upper_oe_n <= !(dec_wide & sel_host);
            pci_only_pins_oe_n   <= sel_host;
            shared_gpio_func     <= next_gpio_func;
            shared_gpio_oe_n     <= next_gpio_oe_n;
        end
    end
endmodule

// [rtl/strap_cfg_pkg.sv]
// constants for the reset strap configuration decoder
package strap_cfg_pkg;
    // register byte offsets
    localparam logic [7:0] REG_STRAP_STATUS = 8'h00;
    localparam logic [7:0] REG_GPIO_ENABLE  = 8'h04;
    localparam logic [7:0] REG_GPIO_DIR     = 8'h08;
    localparam logic [7:0] REG_PIN_SELECT   = 8'h0C;
    localparam logic [7:0] REG_ID           = 8'h10;
    // status field positions
    localparam int ST_PCI_SEL   = 0;
    localparam int ST_BYTE_ORD  = 1;
    localparam int ST_BOOT_LO   = 2;
    localparam int ST_MCLK_LO   = 4;
    localparam int ST_AUTOINIT  = 6;
    localparam int ST_HWIDTH    = 7;
    localparam int ST_BOOT_RSV  = 8;
    localparam int ST_MCLK_RSV  = 9;
    localparam int ST_EE_CONFL  = 10;
    localparam int ST_CAPTURED  = 11;
    localparam int GPIO_W       = 7;
    localparam logic [6:0] GPIO_EN_RST  = 7'h00;
    localparam logic [6:0] GPIO_DIR_RST = 7'h00;
    // arbitrary identification value
    localparam logic [31:0] BLOCK_ID    = 32'h5C0F_0001;
    // boot source codes
    typedef enum logic [1:0] {
        BOOT_NONE = 2'b00,
        BOOT_HOST = 2'b01,
        BOOT_RSV  = 2'b10,
        BOOT_ROM8 = 2'b11
    } boot_mode_e;
    // memory clock source codes
    typedef enum logic [1:0] {
        MCLK_INPUT = 2'b00,
        MCLK_DIV4  = 2'b01,
        MCLK_DIV6  = 2'b10,
        MCLK_RSV   = 2'b11
    } mem_clk_e;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

// [sim/strap_board.sv]
// board strap network model
`timescale 1ns/1ps
module strap_board (
    input  wire logic [7:0] want,
    output logic            pci_select_strap,
    output logic            byte_order_strap,
    output logic [1:0]      boot_select_strap,
    output logic [1:0]      memory_clock_select_strap,
    output logic            eeprom_autoinit_strap,
    output logic            host_width_strap
);
    // static levels; only the bench's pattern moves them
    assign pci_select_strap = want[7];
    assign {byte_order_strap, boot_select_strap, memory_clock_select_strap,
            eeprom_autoinit_strap, host_width_strap} = want[6:0];
endmodule

// [sim/strap_cfg_sva.sv]
// port assertions for the strap decoder
`timescale 1ns/1ps
module strap_cfg_sva
    import strap_cfg_pkg::*;
(
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              host_port_enable,
    input wire logic              pci_enable,
    input wire logic              little_endian,
    input wire boot_mode_e        boot_mode,
    input wire mem_clk_e          memory_clock_source,
    input wire logic              pci_eeprom_autoinit,
    input wire logic              host_port_wide,
    input wire logic              host_data_upper_oe_n,
    input wire logic              pci_only_pins_oe_n,
    input wire logic [GPIO_W-1:0] shared_gpio_func,
    input wire logic [GPIO_W-1:0] shared_gpio_oe_n
);
    // edges since release; decoded values settle by the fourth
    logic [2:0] cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt <= 3'h0;
        else if (cnt != 3'h5) cnt <= cnt + 3'h1;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_one_owner: assert property (host_port_enable != pci_enable)
        else $error("shared pins owner not unique");
    chk_pci_hiz: assert property (pci_only_pins_oe_n == !pci_enable)
        else $error("pci only pins enable wrong");
    chk_ee_gate: assert property (pci_eeprom_autoinit |-> pci_enable)
        else $error("autoinit without pci");
    chk_wide_gate: assert property (host_port_wide |-> host_port_enable && !host_data_upper_oe_n)
        else $error("wide host port lanes wrong");
    chk_upper_hiz: assert property (!host_port_wide |-> host_data_upper_oe_n)
        else $error("upper lanes driven when narrow");
    chk_gpio_pci: assert property (pci_enable |-> shared_gpio_func == '0 && &shared_gpio_oe_n)
        else $error("gpio active under pci");
    chk_gpio_oe: assert property ((~shared_gpio_oe_n & ~shared_gpio_func) == '0)
        else $error("gpio driven while not gpio");
    chk_straps_frozen: assert property (cnt == 3'h5 |-> $stable(little_endian) && $stable(boot_mode)
        && $stable(memory_clock_source) && $stable(pci_enable) && $stable(host_port_wide))
        else $error("captured straps moved");
    cover property (pci_enable && pci_eeprom_autoinit);
    cover property (host_port_wide);
    cover property (shared_gpio_oe_n != '1);
endmodule

// [sim/test_reset_strap_config_decoder.sv]
// self-checking bench for the strap decoder
`timescale 1ns/1ps
module test_reset_strap_config_decoder;
    import strap_cfg_pkg::*;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, pse, bos, eas, hws;
    logic        hpe, pe, le, ea, hw, uoe, poe;
    logic [1:0]  htrans, bss, mcs;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [7:0]  want;
    logic [6:0]  gf, goe;
    boot_mode_e  bm;
    mem_clk_e    mc;
    int          n_mismatch = 0, n_tests = 0, cycles = 0;
    strap_board i_strap_board (.want(want), .pci_select_strap(pse), .byte_order_strap(bos),
        .boot_select_strap(bss), .memory_clock_select_strap(mcs),
        .eeprom_autoinit_strap(eas), .host_width_strap(hws));
    reset_strap_config_decoder i_reset_strap_config_decoder (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pci_select_strap(pse), .byte_order_strap(bos),
        .boot_select_strap(bss), .memory_clock_select_strap(mcs),
        .eeprom_autoinit_strap(eas), .host_width_strap(hws), .host_port_enable(hpe),
        .pci_enable(pe), .little_endian(le), .boot_mode(bm), .memory_clock_source(mc),
        .pci_eeprom_autoinit(ea), .host_port_wide(hw), .host_data_upper_oe_n(uoe),
        .pci_only_pins_oe_n(poe), .shared_gpio_func(gf), .shared_gpio_oe_n(goe));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic run_cfg(input logic [7:0] w);
        logic p;
        p = w[7];
        @(posedge hclk);
        want <= w;
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        // later strap moves must be ignored; the select strap stays put
        // the moved pattern keeps the boot code valid and autoinit low without pci
        want[6:0] <= {~w[6], ((w[5:4] == 2'b00) ? 2'b11 : 2'b00), ~w[3:2], p & !w[1], ~w[0]};
        repeat (3) @(posedge hclk);
        chk("host_en", hpe, !p);
        chk("pci_en", pe, p);
        chk("pci_oe_n", poe, !p);
        chk("little", le, w[6]);
        chk("boot", bm, w[5:4]);
        chk("mclk", mc, w[3:2]);
        chk("autoinit", ea, w[1] & p);
        chk("wide", hw, w[0] & !p);
        chk("upper_oe_n", uoe, !(w[0] & !p));
        bus(1'b0, REG_STRAP_STATUS, 32'h0);
        chk("status", d, {20'h0, 1'b1, w[1] & !p, w[3:2] == 2'b11,
            w[5:4] == 2'b10, w[0], w[1] & p, w[3:2], w[5:4], w[6], p});
        chk("resp", {30'h0, hreadyout, hresp}, 32'h2);
        bus(1'b1, REG_GPIO_ENABLE, 32'h55);
        bus(1'b1, REG_GPIO_DIR, 32'h0F);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        repeat (3) @(posedge hclk);
        chk("gpio_func", gf, p ? 7'h00 : 7'h55);
        chk("gpio_oe_n", goe, p ? 7'h7F : 7'h7A);
        bus(1'b1, REG_GPIO_DIR, 32'h70);
        repeat (3) @(posedge hclk);
        chk("gpio_oe_n2", goe, p ? 7'h7F : 7'h2F);
        bus(1'b0, REG_GPIO_ENABLE, 32'h0);
        chk("en_rd", d, 32'h55);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", d, 32'h0);
        bus(1'b0, REG_ID, 32'h0);
        chk("id", d, BLOCK_ID);
        $display("config %h done", w);
    endtask
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        hresetn = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        want = 8'h00;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        run_cfg(8'h00);
        run_cfg(8'h55);
        run_cfg(8'hFB);
        run_cfg(8'hBC);
        wrap_up();
    end
endmodule
bind reset_strap_config_decoder strap_cfg_sva i_strap_cfg_sva (.hclk(hclk), .hresetn(hresetn),
    .host_port_enable(host_port_enable), .pci_enable(pci_enable),
    .little_endian(little_endian), .boot_mode(boot_mode),
    .memory_clock_source(memory_clock_source), .pci_eeprom_autoinit(pci_eeprom_autoinit),
    .host_port_wide(host_port_wide), .host_data_upper_oe_n(host_data_upper_oe_n),
    .pci_only_pins_oe_n(pci_only_pins_oe_n), .shared_gpio_func(shared_gpio_func),
    .shared_gpio_oe_n(shared_gpio_oe_n));
